// ### hw/logger_pkg.sv
// Shared constants, register map and types of the binary event logger.
// Assumes a single 100 MHz clock and the plain register port of the top.
package logger_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
   localparam int MS_PERIOD_NS = 1_000_000;
   localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
   localparam int FLASH_HALF_MS = 250;
   localparam int NUM_CH = 96;
   localparam int CH_W = 7;
   localparam int LIST_DEPTH = 1000;
   localparam int REC_MAX = 150;
   localparam int NUM_SLOTS = 2;

   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_POST_MS = 8'h08;
   localparam logic [7:0] OFF_LIMIT_MS = 8'h0C;
   localparam logic [7:0] OFF_TRIG_EDGE = 8'h10;
   localparam logic [7:0] OFF_TRIG_EN = 8'h20;
   localparam logic [7:0] OFF_IND_MASK = 8'h30;
   localparam logic [7:0] OFF_LAMP_EN = 8'h40;
   localparam logic [7:0] OFF_IND_SEEN = 8'h50;
   localparam logic [7:0] OFF_LIST_IDX = 8'h60;
   localparam logic [7:0] OFF_LIST_STAMP = 8'h64;
   localparam logic [7:0] OFF_LIST_ID = 8'h68;
   localparam logic [7:0] OFF_STAMP = 8'h6C;

   localparam int CTRL_OPERATION = 0;
   localparam int CTRL_NEWEST_FIRST = 1;
   localparam int CTRL_RETRIGGER = 2;
   localparam int CTRL_TEST_MODE = 3;
   localparam int CTRL_CONFIG_MODE = 4;
   localparam int CTRL_MANUAL_TRIG = 5;
   localparam int CTRL_LAMP_CLEAR = 6;
   localparam int CTRL_LIST_CLEAR = 7;
   localparam int STATUS_COUNT_LSB = 16;

   localparam logic [4:0] CTRL_RST = 5'h00;
   localparam logic [15:0] POST_MS_RST = 16'h0064;
   localparam logic [15:0] LIMIT_MS_RST = 16'h03E8;
   localparam logic [95:0] TRIG_EDGE_RST = 96'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF;
   localparam logic [95:0] MASK_RST = 96'h0000_0000_0000_0000_0000_0000;

   typedef struct packed {
      logic [CH_W-1:0] chan;
      logic state;
      logic [31:0] stamp;
   } event_t;

   typedef enum logic [1:0] {
      SLOT_IDLE = 2'b00,
      SLOT_POST = 2'b01,
      SLOT_END = 2'b10
   } slot_state_t;
endpackage

// ### hw/ring_mem.sv
// Simple dual-port word store for the event list ring.
// Assumes one clock; read data are registered, one cycle after the address.
`timescale 1ns/100ps
`default_nettype none
module ring_mem #(
   parameter int WIDTH = 40,
   parameter int DEPTH = 1000,
   parameter int AW = 10
) (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule
`default_nettype wire

// ### hw/binary_event_logger.sv
// Event list, indication tracker, event recorder and status lamps.
// Assumes logic_sig and analog_trig come from logic on clk; pin_sig are
// asynchronous input channels; a storage unit takes rec_* outputs.
//
// Notes on behaviour
// - each signal change appends channel, new state and ms stamp, in order.
// - event list keeps up to 1000 entries in a ring.
// - when full, the newest event overwrites the oldest.
// - a setting chooses oldest-first or newest-first readout.
// - event list logging runs always, recording or not.
// - event list storage is kept apart from recording storage.
// - green lamp steady in service, flashing on fail, dark unpowered.
// - yellow lamp steady after trigger, flashing in test or config mode.
// - red lamp lights when channel N triggered with its lamp enable on.
// - indications catch only rising edges during the recording window.
// - indications carry no stamp, only which signals rose.
// - indication needs group connection, operation on and a trigger.
// - per-channel select mask picks indication channels.
// - up to 96 indications per disturbance, kept for 100 reports.
// - after any trigger, the recorder logs every change of 96 signals.
// - at most 150 events per recording, kept for 100 reports.
// - logic events stamped centrally, input channels stamped at sampling.
// - events gathered over the whole recording, stored when it ends.
// - with retrigger on, overlapping events go to both recordings.
// - per-channel edge setting: 1 triggers rising, 0 triggers falling.
// - per-channel lamp enable, off by default, gates the red lamp.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module binary_event_logger #(
   parameter int NUM_PINS = 48,
   parameter int MS_CYCLES = logger_pkg::MS_CYCLES,
   parameter int LIST_DEPTH = logger_pkg::LIST_DEPTH,
   parameter int REC_MAX = logger_pkg::REC_MAX
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic [logger_pkg::NUM_CH-NUM_PINS-1:0] logic_sig,
   input wire logic [NUM_PINS-1:0] pin_sig,
   input wire logic analog_trig,
   input wire logic internal_fail,
   output logic green_lamp,
   output logic yellow_lamp,
   output logic red_lamp,
   output logic rec_valid,
   output logger_pkg::event_t rec_event,
   output logic [logger_pkg::NUM_SLOTS-1:0] rec_slots,
   output logic [logger_pkg::NUM_SLOTS-1:0] rec_end,
   output logic [logger_pkg::NUM_CH-1:0] ind_seen
);
   localparam int NCH = logger_pkg::NUM_CH;
   localparam int NL = NCH - NUM_PINS;
   localparam int NS = logger_pkg::NUM_SLOTS;
   localparam int AW = $clog2(LIST_DEPTH);

   function automatic logic [AW-1:0] wrap(input logic [AW-1:0] a, input logic [AW-1:0] b);
      logic [AW:0] s;
      s = {1'b0, a} + {1'b0, b};
      if (s >= (AW+1)'(LIST_DEPTH))
      begin
         s = s - (AW+1)'(LIST_DEPTH);
      end
      wrap = s[AW-1:0];
   endfunction

   function automatic logic [NCH-1:0] put_word(input logic [NCH-1:0] cur,
         input logic [7:0] base, input logic [7:0] a, input logic [31:0] d);
      put_word = cur;
      for (int w = 0; w < NCH / 32; w++)
      begin
         if (a == base + 8'(4 * w))
         begin
            put_word[32*w +: 32] = d;
         end
      end
   endfunction

   function automatic logic [31:0] get_word(input logic [NCH-1:0] cur,
         input logic [7:0] base, input logic [7:0] a);
      get_word = 32'h0000_0000;
      for (int w = 0; w < NCH / 32; w++)
      begin
         if (a == base + 8'(4 * w))
         begin
            get_word = cur[32*w +: 32];
         end
      end
   endfunction

   function automatic logic [logger_pkg::CH_W-1:0] first_set(input logic [NCH-1:0] v);
      first_set = '0;
      for (int i = NCH - 1; i >= 0; i--)
      begin
         if (v[i])
         begin
            first_set = logger_pkg::CH_W'(i);
         end
      end
   endfunction

   // Configuration registers.
   logic [4:0] ctrl, next_ctrl;
   logic [15:0] post_ms, next_post_ms, limit_ms, next_limit_ms;
   logic [NCH-1:0] trig_edge, next_trig_edge, trig_en, next_trig_en;
   logic [NCH-1:0] ind_mask, next_ind_mask, lamp_en, next_lamp_en;
   logic [AW-1:0] list_idx, next_list_idx;
   logic wr_ctrl, manual_trig, lamp_clear, list_clear, operation;

   assign wr_ctrl = wr && addr == logger_pkg::OFF_CTRL;
   assign manual_trig = wr_ctrl && wdata[logger_pkg::CTRL_MANUAL_TRIG];
   assign lamp_clear = wr_ctrl && wdata[logger_pkg::CTRL_LAMP_CLEAR];
   assign list_clear = wr_ctrl && wdata[logger_pkg::CTRL_LIST_CLEAR];
   assign operation = ctrl[logger_pkg::CTRL_OPERATION];

   always_comb
   begin
      next_ctrl = wr_ctrl ? wdata[4:0] : ctrl;
      next_post_ms = (wr && addr == logger_pkg::OFF_POST_MS) ? wdata[15:0] : post_ms;
      next_limit_ms = (wr && addr == logger_pkg::OFF_LIMIT_MS) ? wdata[15:0] : limit_ms;
      next_list_idx = (wr && addr == logger_pkg::OFF_LIST_IDX) ? wdata[AW-1:0] : list_idx;
      next_trig_edge = trig_edge;
      next_trig_en = trig_en;
      next_ind_mask = ind_mask;
      next_lamp_en = lamp_en;
      if (wr)
      begin
         next_trig_edge = put_word(trig_edge, logger_pkg::OFF_TRIG_EDGE, addr, wdata);
         next_trig_en = put_word(trig_en, logger_pkg::OFF_TRIG_EN, addr, wdata);
         next_ind_mask = put_word(ind_mask, logger_pkg::OFF_IND_MASK, addr, wdata);
         next_lamp_en = put_word(lamp_en, logger_pkg::OFF_LAMP_EN, addr, wdata);
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctrl <= logger_pkg::CTRL_RST;
         post_ms <= logger_pkg::POST_MS_RST;
         limit_ms <= logger_pkg::LIMIT_MS_RST;
         list_idx <= '0;
         trig_edge <= logger_pkg::TRIG_EDGE_RST;
         trig_en <= logger_pkg::MASK_RST;
         ind_mask <= logger_pkg::MASK_RST;
         lamp_en <= logger_pkg::MASK_RST;
      end
      else
      begin
         ctrl <= next_ctrl;
         post_ms <= next_post_ms;
         limit_ms <= next_limit_ms;
         list_idx <= next_list_idx;
         trig_edge <= next_trig_edge;
         trig_en <= next_trig_en;
         ind_mask <= next_ind_mask;
         lamp_en <= next_lamp_en;
      end
   end

   // Millisecond time base and lamp flash rate.
   logic [31:0] ms_div, next_ms_div, stamp, next_stamp;
   logic [15:0] flash_cnt, next_flash_cnt;
   logic blink, next_blink, tick;

   assign tick = ms_div == 32'(MS_CYCLES - 1);

   always_comb
   begin
      next_ms_div = tick ? 32'h0000_0000 : ms_div + 32'h0000_0001;
      next_stamp = tick ? stamp + 32'h0000_0001 : stamp;
      next_flash_cnt = flash_cnt;
      next_blink = blink;
      if (tick)
      begin
         next_flash_cnt = flash_cnt + 16'h0001;
         if (flash_cnt == 16'(logger_pkg::FLASH_HALF_MS - 1))
         begin
            next_flash_cnt = 16'h0000;
            next_blink = !blink;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ms_div <= 32'h0000_0000;
         stamp <= 32'h0000_0000;
         flash_cnt <= 16'h0000;
         blink <= 1'b0;
      end
      else
      begin
         ms_div <= next_ms_div;
         stamp <= next_stamp;
         flash_cnt <= next_flash_cnt;
         blink <= next_blink;
      end
   end

   // Input sampling, change detection and the pending-change queue.
   // Simultaneous changes wait in a bitmap and leave lowest channel first,
   // so one event per cycle; the delay stays far below one millisecond.
   logic [NUM_PINS-1:0] pin_s1, pin_s2, pin_s3, pin_val, next_pin_val;
   logic [31:0] pin_stamp [NUM_PINS];
   logic [31:0] next_pin_stamp [NUM_PINS];
   logic [NCH-1:0] chan, prev, pend, next_pend, rise, fall, trig_hit;
   logic [logger_pkg::CH_W-1:0] svc_idx;
   logic svc_valid;
   logger_pkg::event_t svc_event;

   assign chan = {pin_val, logic_sig};
   assign rise = chan & ~prev;
   assign fall = ~chan & prev;
   assign trig_hit = trig_en & ((trig_edge & rise) | (~trig_edge & fall));
   assign svc_valid = |pend;
   assign svc_idx = first_set(pend);

   always_comb
   begin
      next_pin_val = pin_val;
      for (int k = 0; k < NUM_PINS; k++)
      begin
         next_pin_stamp[k] = pin_stamp[k];
         if (pin_s2[k] == pin_s3[k] && pin_s3[k] != pin_val[k])
         begin
            next_pin_val[k] = pin_s3[k];
            next_pin_stamp[k] = stamp;
         end
      end
      next_pend = pend;
      if (svc_valid)
      begin
         next_pend[svc_idx] = 1'b0;
      end
      next_pend = next_pend | (chan ^ prev);
      svc_event.chan = svc_idx;
      svc_event.state = chan[svc_idx];
      svc_event.stamp = stamp;
      if (int'(svc_idx) >= NL)
      begin
         svc_event.stamp = pin_stamp[int'(svc_idx) - NL];
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         pin_s3 <= '0;
         pin_val <= '0;
         prev <= '0;
         pend <= '0;
         for (int k = 0; k < NUM_PINS; k++)
         begin
            pin_stamp[k] <= 32'h0000_0000;
         end
      end
      else
      begin
         pin_s1 <= pin_sig;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_val <= next_pin_val;
         prev <= chan;
         pend <= next_pend;
         pin_stamp <= next_pin_stamp;
      end
   end

   // Event list ring; it has its own store and its own clear.
   logic [AW-1:0] wr_ptr, next_wr_ptr, rd_addr, oldest;
   logic [AW:0] count, next_count;
   logic [logger_pkg::CH_W+32:0] list_q;
   logger_pkg::event_t list_entry;

   assign list_entry = logger_pkg::event_t'(list_q);
   assign oldest = (count == (AW+1)'(LIST_DEPTH)) ? wr_ptr : '0;

   always_comb
   begin
      next_wr_ptr = list_clear ? '0 : wr_ptr;
      next_count = list_clear ? '0 : count;
      if (svc_valid)
      begin
         next_wr_ptr = wrap(next_wr_ptr, AW'(1));
         if (next_count != (AW+1)'(LIST_DEPTH))
         begin
            next_count = next_count + (AW+1)'(1);
         end
      end
      if (ctrl[logger_pkg::CTRL_NEWEST_FIRST])
      begin
         rd_addr = wrap(wr_ptr, AW'(LIST_DEPTH - 1) - list_idx);
      end
      else
      begin
         rd_addr = wrap(oldest, list_idx);
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wr_ptr <= '0;
         count <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         count <= next_count;
      end
   end

   ring_mem #(
      .WIDTH(logger_pkg::CH_W + 33),
      .DEPTH(LIST_DEPTH),
      .AW(AW)
   ) list_store (
      .clk(clk),
      .wr_en(svc_valid),
      .wr_addr(list_clear ? '0 : wr_ptr),
      .wr_data(svc_event),
      .rd_addr(rd_addr),
      .rd_data(list_q)
   );

   // Recording slots. Two slots let a retrigger overlap the running one.
   logger_pkg::slot_state_t st [NS];
   logger_pkg::slot_state_t next_st [NS];
   logic [15:0] post_cnt [NS];
   logic [15:0] next_post_cnt [NS];
   logic [15:0] lim_cnt [NS];
   logic [15:0] next_lim_cnt [NS];
   logic [7:0] ev_cnt [NS];
   logic [7:0] next_ev_cnt [NS];
   logic [NS-1:0] rec_mask, busy;
   logic trig_now, extend, started, retrig;

   assign retrig = ctrl[logger_pkg::CTRL_RETRIGGER];
   assign trig_now = operation && (|trig_hit || manual_trig || analog_trig);

   always_comb
   begin
      rec_mask = '0;
      started = 1'b0;
      for (int i = 0; i < NS; i++)
      begin
         busy[i] = st[i] == logger_pkg::SLOT_POST;
      end
      extend = trig_now && (!retrig || &busy) && |busy;
      for (int i = 0; i < NS; i++)
      begin
         next_st[i] = st[i];
         next_post_cnt[i] = post_cnt[i];
         next_lim_cnt[i] = lim_cnt[i];
         next_ev_cnt[i] = ev_cnt[i];
         case (st[i])
            logger_pkg::SLOT_POST:
            begin
               if (svc_valid && ev_cnt[i] < 8'(REC_MAX))
               begin
                  rec_mask[i] = 1'b1;
                  next_ev_cnt[i] = ev_cnt[i] + 8'h01;
               end
               if (tick)
               begin
                  next_lim_cnt[i] = lim_cnt[i] - 16'h0001;
                  next_post_cnt[i] = post_cnt[i] - 16'h0001;
               end
               if (extend)
               begin
                  next_post_cnt[i] = post_ms;
               end
               if (tick && (lim_cnt[i] <= 16'h0001 || (!extend && post_cnt[i] <= 16'h0001)))
               begin
                  next_st[i] = logger_pkg::SLOT_END;
               end
            end
            logger_pkg::SLOT_END:
            begin
               next_st[i] = logger_pkg::SLOT_IDLE;
            end
            default:
            begin
               if (trig_now && !started && !extend && (retrig || busy == '0))
               begin
                  started = 1'b1;
                  next_st[i] = logger_pkg::SLOT_POST;
                  next_post_cnt[i] = post_ms;
                  next_lim_cnt[i] = limit_ms;
                  rec_mask[i] = svc_valid;
                  next_ev_cnt[i] = {7'h00, svc_valid};
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < NS; i++)
         begin
            st[i] <= logger_pkg::SLOT_IDLE;
            post_cnt[i] <= 16'h0000;
            lim_cnt[i] <= 16'h0000;
            ev_cnt[i] <= 8'h00;
         end
         rec_valid <= 1'b0;
         rec_slots <= '0;
         rec_event <= '0;
      end
      else
      begin
         st <= next_st;
         post_cnt <= next_post_cnt;
         lim_cnt <= next_lim_cnt;
         ev_cnt <= next_ev_cnt;
         rec_valid <= |rec_mask;
         rec_slots <= rec_mask;
         rec_event <= svc_event;
      end
   end

   always_comb
   begin
      for (int i = 0; i < NS; i++)
      begin
         rec_end[i] = st[i] == logger_pkg::SLOT_END;
      end
   end

   // Indications and lamps. A lamp clear and a new cause in one cycle keep
   // the cause.
   logic [NCH-1:0] next_ind_seen;
   logic triggered, next_triggered, red_hit, next_red_hit;
   logic next_green, next_yellow;

   always_comb
   begin
      next_ind_seen = ind_seen;
      if (started && busy == '0)
      begin
         next_ind_seen = '0;
      end
      if (operation && |busy)
      begin
         next_ind_seen = next_ind_seen | (rise & ind_mask);
      end
      next_triggered = (triggered && !lamp_clear) || trig_now;
      next_red_hit = (red_hit && !lamp_clear) || (trig_now && |(trig_hit & lamp_en));
      next_green = internal_fail ? blink : 1'b1;
      next_yellow = next_triggered;
      if (ctrl[logger_pkg::CTRL_TEST_MODE] || ctrl[logger_pkg::CTRL_CONFIG_MODE])
      begin
         next_yellow = blink;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ind_seen <= '0;
         triggered <= 1'b0;
         red_hit <= 1'b0;
         green_lamp <= 1'b0;
         yellow_lamp <= 1'b0;
         red_lamp <= 1'b0;
      end
      else
      begin
         ind_seen <= next_ind_seen;
         triggered <= next_triggered;
         red_hit <= next_red_hit;
         green_lamp <= next_green;
         yellow_lamp <= next_yellow;
         red_lamp <= next_red_hit;
      end
   end

   // Register read port; unmapped addresses read as zero.
   logic [31:0] next_rdata;

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (rd)
      begin
         case (addr)
            logger_pkg::OFF_CTRL: next_rdata = {27'h000_0000, ctrl};
            logger_pkg::OFF_STATUS: next_rdata = {5'h00, count, 12'h000, red_hit, triggered, busy};
            logger_pkg::OFF_POST_MS: next_rdata = {16'h0000, post_ms};
            logger_pkg::OFF_LIMIT_MS: next_rdata = {16'h0000, limit_ms};
            logger_pkg::OFF_LIST_IDX: next_rdata = 32'(list_idx);
            logger_pkg::OFF_LIST_STAMP: next_rdata = list_entry.stamp;
            logger_pkg::OFF_LIST_ID: next_rdata = 32'({list_entry.state, list_entry.chan});
            logger_pkg::OFF_STAMP: next_rdata = stamp;
            default:
            begin
               next_rdata = get_word(trig_edge, logger_pkg::OFF_TRIG_EDGE, addr)
                  | get_word(trig_en, logger_pkg::OFF_TRIG_EN, addr)
                  | get_word(ind_mask, logger_pkg::OFF_IND_MASK, addr)
                  | get_word(lamp_en, logger_pkg::OFF_LAMP_EN, addr)
                  | get_word(ind_seen, logger_pkg::OFF_IND_SEEN, addr);
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rdata <= 32'h0000_0000;
      end
      else
      begin
         rdata <= next_rdata;
      end
   end
endmodule
`default_nettype wire

// ### tb/binary_event_logger_monitor.sv
// Port-level assertions for the binary event logger.
// Assumes one clock clk and the active-high reset sys_rst.
`timescale 1ns/100ps
`default_nettype none
module binary_event_logger_monitor #(
   parameter int REC_MAX = 150
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic internal_fail,
   input wire logic green_lamp,
   input wire logic yellow_lamp,
   input wire logic rec_valid,
   input wire logger_pkg::event_t rec_event,
   input wire logic [1:0] rec_slots,
   input wire logic [1:0] rec_end,
   input wire logic [95:0] ind_seen
);
   int n0;
   int next_n0;
   always_comb
   begin
      next_n0 = n0;
      if (rec_end[0])
         next_n0 = 0;
      else if (rec_valid && rec_slots[0])
         next_n0 = n0 + 1;
   end
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         n0 <= 0;
      else
         n0 <= next_n0;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   chk_green_service: assert property (!internal_fail [*2] |=> green_lamp)
      else $error("green lamp not steady in service");
   chk_end_closes: assert property (rec_end[0] |=> !(rec_valid && rec_slots[0]))
      else $error("event after recording end");
   chk_end_single: assert property (rec_end[0] |=> !rec_end[0])
      else $error("end pulse too long");
   chk_event_owned: assert property (rec_valid |-> rec_slots != 2'b00)
      else $error("event without recording");
   chk_chan_range: assert property (rec_valid |-> rec_event.chan < 7'd96)
      else $error("event channel out of range");
   chk_rec_ceiling: assert property (n0 <= REC_MAX)
      else $error("too many events in one recording");
   chk_ind_trig: assert property (|(ind_seen & ~$past(ind_seen)) |-> yellow_lamp)
      else $error("indication without trigger");
   chk_rdata_quiet: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
      else $error("read data outside read cycle");
   cover property (rec_end[0]);
   cover property (rec_valid && rec_slots[0]);
   cover property (internal_fail && !green_lamp);
endmodule
bind binary_event_logger binary_event_logger_monitor #(.REC_MAX(REC_MAX)) monitor_i (
   .clk(clk),
   .sys_rst(sys_rst),
   .rd(rd),
   .rdata(rdata),
   .internal_fail(internal_fail),
   .green_lamp(green_lamp),
   .yellow_lamp(yellow_lamp),
   .rec_valid(rec_valid),
   .rec_event(rec_event),
   .rec_slots(rec_slots),
   .rec_end(rec_end),
   .ind_seen(ind_seen)
);
`default_nettype wire

// ### tb/signal_source.sv
// Model of the logic signals and input channels feeding the logger.
// Assumes a toggle request go with channel ch, sampled on clk.
`timescale 1ns/100ps
`default_nettype none
module signal_source (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic go,
   input wire logic [6:0] ch,
   output logic [47:0] logic_sig,
   output logic [47:0] pin_sig
);
   // Input channels are not tied to clk, so they move 3 ns after the edge.
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         logic_sig <= '0;
         pin_sig <= '0;
      end
      else if (go && ch < 7'd48)
         logic_sig[ch] <= ~logic_sig[ch];
      else if (go)
         pin_sig[ch - 7'd48] <= #3 ~pin_sig[ch - 7'd48];
   end
endmodule
`default_nettype wire

// ### tb/binary_event_logger_tb.sv
// Self-checking bench for the binary event logger.
// Assumes the logger package is compiled first.
`timescale 1ns/100ps
`default_nettype none
module binary_event_logger_tb;
   logic clk = 0;
   logic sys_rst = 1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 0;
   logic rd = 0;
   logic internal_fail = 0;
   logic analog_trig = 0;
   logic go = 0;
   logic [6:0] ch = 7'h00;
   logic [31:0] rdata, d;
   logic [47:0] logic_sig, pin_sig;
   logic green_lamp, yellow_lamp, red_lamp, rec_valid;
   logger_pkg::event_t rec_event;
   logic [1:0] rec_slots, rec_end;
   logic [95:0] ind_seen;
   logic [95:0] lvl = '0;
   int seed = 41;
   int fail_count = 0;
   int cmp_count = 0;
   int nrec = 0;
   int ends = 0;
   int lastc = 0;
   int tog = 0;
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      if (rec_valid && rec_slots[0])
         nrec <= nrec + 1;
      if (rec_end[0])
         ends <= ends + 1;
   end
   signal_source signal_source_i (.clk(clk), .sys_rst(sys_rst), .go(go), .ch(ch),
      .logic_sig(logic_sig), .pin_sig(pin_sig));
   binary_event_logger #(.MS_CYCLES(10)) binary_event_logger_i (.clk(clk),
      .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .logic_sig(logic_sig), .pin_sig(pin_sig), .analog_trig(analog_trig),
      .internal_fail(internal_fail), .green_lamp(green_lamp), .yellow_lamp(yellow_lamp),
      .red_lamp(red_lamp), .rec_valid(rec_valid), .rec_event(rec_event),
      .rec_slots(rec_slots), .rec_end(rec_end), .ind_seen(ind_seen));
   task automatic conclude();
      if (fail_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      wr <= 1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 0;
   endtask
   task automatic rreg(input logic [7:0] a);
      @(posedge clk);
      rd <= 1;
      addr <= a;
      @(posedge clk);
      rd <= 0;
      #1 d = rdata;
   endtask
   // Toggles are spaced so the input synchronizer sees every pin change.
   task automatic flip(input int c);
      @(posedge clk);
      go <= 1;
      ch <= c[6:0];
      lvl[c] = ~lvl[c];
      lastc = c;
      @(posedge clk);
      go <= 0;
      repeat (3) @(posedge clk);
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      sys_rst <= 0;
      repeat (2) @(posedge clk);
      #1 check(32'(green_lamp), 32'h0000_0001);
      check(32'(yellow_lamp | red_lamp), 32'h0000_0000);
      rreg(logger_pkg::OFF_LAMP_EN);
      check(d, 32'h0000_0000);
      wreg(logger_pkg::OFF_CTRL, 32'h0000_0001);
      wreg(logger_pkg::OFF_TRIG_EN, 32'h0000_0008);
      wreg(logger_pkg::OFF_LAMP_EN, 32'h0000_0008);
      wreg(logger_pkg::OFF_IND_MASK, 32'h0000_0028);
      flip(5);
      rreg(logger_pkg::OFF_STATUS);
      check(32'(d[26:16]), 32'h0000_0001);
      rreg(logger_pkg::OFF_LIST_ID);
      check(32'(d[7:0]), 32'h0000_0085);
      check(32'(nrec), 32'h0000_0000);
      flip(3);
      check(32'({yellow_lamp, red_lamp}), 32'h0000_0003);
      // The triggering rise precedes the window, so a later masked rise is used.
      flip(5);
      check(32'(ind_seen[5]), 32'h0000_0000);
      flip(5);
      check(32'(ind_seen[5]), 32'h0000_0001);
      for (int i = 0; i < 1100; i++)
         flip(8 + ($unsigned($random(seed)) % 88));
      for (int k = 0; k < 20000 && ends == 0; k++)
         @(posedge clk);
      check(32'(ends), 32'h0000_0001);
      check(32'(nrec), 32'h0000_0096);
      rreg(logger_pkg::OFF_STATUS);
      check(32'(d[26:16]), 32'h0000_03E8);
      for (int m = 0; m < 2; m++)
      begin
         wreg(logger_pkg::OFF_CTRL, 32'(1 + 2 * m));
         wreg(logger_pkg::OFF_LIST_IDX, m ? 32'h0000_0000 : 32'h0000_03E7);
         rreg(logger_pkg::OFF_LIST_ID);
         check(32'(d[7:0]), 32'({lvl[lastc], lastc[6:0]}));
      end
      @(posedge clk);
      internal_fail <= 1;
      d[0] = green_lamp;
      for (int k = 0; k < 8000; k++)
      begin
         @(posedge clk);
         #1 tog += 32'(green_lamp !== d[0]);
         d[0] = green_lamp;
      end
      check(32'(tog > 2), 32'h0000_0001);
      conclude();
   end
endmodule
`default_nettype wire
